/* File: rtl/direction_change_detector.sv */
// Direction-change detector with hysteresis and latched source
`timescale 1ns/1ps
module direction_change_detector
    import direction_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Samples, one strobe per output data rate period
    input  wire logic                   sample_valid_i,
    input  wire direction_pkg::sample_t raw_x_i,
    input  wire direction_pkg::sample_t raw_y_i,
    input  wire direction_pkg::sample_t raw_z_i,
    input  wire direction_pkg::sample_t filt_x_i,
    input  wire direction_pkg::sample_t filt_y_i,
    input  wire direction_pkg::sample_t filt_z_i,
    input  wire logic                   direction_filter_select_i,
    // Register port
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [7:0]             reg_wdata_i,
    output logic [7:0]                  reg_rdata_o,
    // Interrupt
    output logic                        direction_irq_o
);
    import direction_pkg::*;

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    logic [7:0]  config_r;
    logic [7:0]  source_r;
    logic [15:0] inner_r;
    logic [15:0] outer_r;
    logic [7:0]  rdata_r;
    logic        irq_r;
    logic [5:0]  flags_r;

    logic        cfg_irq_en;
    logic        cfg_latch;
    logic [5:0]  cfg_event_en;
    logic [7:0]  config_nxt;
    // Interrupt and event enables follow a config write on the same edge; the latch bit one edge late
    assign config_nxt   = (reg_wr_i && reg_addr_i == ADDR_CONFIG)
                          ? reg_wdata_i : config_r;
    assign cfg_irq_en   = config_nxt[CFG_IRQ_EN_BIT];
    assign cfg_latch    = config_r[CFG_LATCH_BIT];
    assign cfg_event_en = config_nxt[5:0];

    //------------------------------------------------------------------
    // Sample selection and comparators
    //------------------------------------------------------------------
    sample_t sx;
    sample_t sy;
    sample_t sz;
    assign sx = direction_filter_select_i ? filt_x_i : raw_x_i; // [RULE12]
    assign sy = direction_filter_select_i ? filt_y_i : raw_y_i; // [RULE12]
    assign sz = direction_filter_select_i ? filt_z_i : raw_z_i; // [RULE12]

    axis_bus_if ax ();
    axis_bus_if ay ();
    axis_bus_if az ();
    assign ax.sample    = sx;
    assign ay.sample    = sy;
    assign az.sample    = sz;
    assign ax.inner_thr = inner_r;                             // [RULE10]
    assign ay.inner_thr = inner_r;
    assign az.inner_thr = inner_r;
    assign ax.outer_thr = outer_r;                             // [RULE11]
    assign ay.outer_thr = outer_r;
    assign az.outer_thr = outer_r;
    // Flag order: zh zl yh yl xh xl
    assign az.high_prev = flags_r[5];
    assign az.low_prev  = flags_r[4];
    assign ay.high_prev = flags_r[3];
    assign ay.low_prev  = flags_r[2];
    assign ax.high_prev = flags_r[1];
    assign ax.low_prev  = flags_r[0];

    axis_hysteresis u_x (.ab(ax));
    axis_hysteresis u_y (.ab(ay));
    axis_hysteresis u_z (.ab(az));

    logic [5:0] flags_nxt;
    assign flags_nxt = {az.high_next, az.low_next, ay.high_next,
                        ay.low_next, ax.high_next, ax.low_next};

    //------------------------------------------------------------------
    // Source evaluation
    //------------------------------------------------------------------
    logic       change_nxt;
    logic [7:0] fresh_src;
    logic       ack_rd;
    logic       held;
    logic [7:0] source_nxt;
    logic       irq_nxt;

    // Direction is the set of axis flags; a change is any difference
    assign change_nxt = flags_nxt != flags_r;                  // [RULE5]
    assign fresh_src  = {1'b0, change_nxt, flags_nxt};
    assign ack_rd     = reg_rd_i && (reg_addr_i == ADDR_ACK);  // [RULE9]
    // Latched: a held event stays until acknowledged; new events OR in
    assign held       = cfg_latch && source_r[SRC_CHANGE_BIT]
                        && !ack_rd;                            // [RULE2]
    assign source_nxt = !sample_valid_i ? (ack_rd ? SOURCE_RESET
                                          : source_r)
                      : held ? (source_r | fresh_src)          // [RULE2]
                      : fresh_src;                             // [RULE13]
    // Event enables select which axis flags raise the interrupt
    assign irq_nxt = cfg_irq_en && source_nxt[SRC_CHANGE_BIT]  // [RULE1]
                     && |(source_nxt[5:0] & cfg_event_en); // [RULE3] [RULE4]

    //------------------------------------------------------------------
    // Register port
    //------------------------------------------------------------------
    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr_i == ADDR_CONFIG)     ? config_r
                  : (reg_addr_i == ADDR_SOURCE)     ? source_r
                  : (reg_addr_i == ADDR_INNER_LOW)  ? inner_r[7:0]
                  : (reg_addr_i == ADDR_INNER_HIGH) ? inner_r[15:8]
                  : (reg_addr_i == ADDR_OUTER_LOW)  ? outer_r[7:0]
                  : (reg_addr_i == ADDR_OUTER_HIGH) ? outer_r[15:8]
                  : READ_ZERO;                                 // [RULE9]

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            config_r <= CONFIG_RESET;
            inner_r  <= THRESHOLD_RESET;
            outer_r  <= THRESHOLD_RESET;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == ADDR_CONFIG)
                config_r <= reg_wdata_i;
            if (reg_addr_i == ADDR_INNER_LOW)
                inner_r[7:0] <= reg_wdata_i;                   // [RULE10]
            if (reg_addr_i == ADDR_INNER_HIGH)
                inner_r[15:8] <= reg_wdata_i;                  // [RULE10]
            if (reg_addr_i == ADDR_OUTER_LOW)
                outer_r[7:0] <= reg_wdata_i;                   // [RULE11]
            if (reg_addr_i == ADDR_OUTER_HIGH)
                outer_r[15:8] <= reg_wdata_i;                  // [RULE11]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_r <= READ_ZERO;
        end else if (ce_i && reg_rd_i) begin
            rdata_r <= rd_mux;
        end
    end

    // Hysteresis state tracks every sample, even while the source is held
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flags_r  <= 6'h00;
            source_r <= SOURCE_RESET;
            irq_r    <= 1'b0;
        end else if (ce_i) begin
            if (sample_valid_i)
                flags_r <= flags_nxt;                          // [RULE6]
            source_r <= source_nxt;
            irq_r    <= irq_nxt;                               // [RULE1]
        end
    end

    assign reg_rdata_o     = rdata_r;
    assign direction_irq_o = irq_r;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    property p_irq_needs_enable;
        @(posedge sys_clk_i) disable iff (rst_i)
        direction_irq_o |-> config_r[CFG_IRQ_EN_BIT];
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable) // [RULE1]
        else $error("interrupt while disabled");

    property p_latch_holds;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && cfg_latch && source_r[SRC_CHANGE_BIT] && !ack_rd
         && !reg_wr_i)
        |=> source_r[SRC_CHANGE_BIT];
    endproperty
    a_latch_holds: assert property (p_latch_holds) // [RULE2]
        else $error("latched event lost");

    property p_high_enable;
        @(posedge sys_clk_i) disable iff (rst_i)
        direction_irq_o |-> |(source_r[5:0] & config_r[5:0]);
    endproperty
    a_high_enable: assert property (p_high_enable) // [RULE3]
        else $error("interrupt without enabled event");

    property p_low_enable;
        @(posedge sys_clk_i) disable iff (rst_i)
        (direction_irq_o && config_r[5:0] == 6'h15)
        |-> |(source_r[4:0] & 5'h15);
    endproperty
    a_low_enable: assert property (p_low_enable) // [RULE4]
        else $error("low-only enables but no low flag");

    property p_change;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && sample_valid_i && !cfg_latch)
        |=> source_r[SRC_CHANGE_BIT] == (flags_r != $past(flags_r));
    endproperty
    a_change: assert property (p_change) // [RULE5]
        else $error("change flag mismatch");

    property p_high_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && sample_valid_i && $signed(sx) > $signed({1'b0, outer_r}))
        |=> flags_r[1];
    endproperty
    a_high_set: assert property (p_high_set) // [RULE6]
        else $error("x high flag not set");

    property p_low_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && sample_valid_i
         && -$signed({sx[15], sx}) > $signed({1'b0, outer_r}))
        |=> flags_r[0];
    endproperty
    a_low_set: assert property (p_low_set) // [RULE7]
        else $error("x low flag not set");

    property p_inner_clear;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && sample_valid_i && outer_r >= inner_r
         && $signed({sx[15], sx}) < $signed({1'b0, inner_r}))
        |=> !flags_r[1];
    endproperty
    a_inner_clear: assert property (p_inner_clear) // [RULE8]
        else $error("x high flag not cleared");

    property p_ack_zero;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && ack_rd) |=> reg_rdata_o == READ_ZERO;
    endproperty
    a_ack_zero: assert property (p_ack_zero) // [RULE9]
        else $error("acknowledge read not zero");

    c_irq:    cover property (@(posedge sys_clk_i) direction_irq_o);
    c_latch:  cover property (@(posedge sys_clk_i)
                              cfg_latch && source_r[SRC_CHANGE_BIT] && ack_rd);
    c_change: cover property (@(posedge sys_clk_i)
                              source_r[SRC_CHANGE_BIT] && !cfg_latch);
endmodule

/* File: rtl/direction_pkg.sv */
// Package of constants and types for the direction-change detector
//----------------------------------------------------------------------
// Functional notes
// RULE1 - Interrupt output only when direction_irq_enable set
// RULE2 - Latch bit holds source until acknowledge read
// RULE3 - Per-axis high enables gate interrupt above threshold
// RULE4 - Per-axis low enables gate interrupt below threshold
// RULE5 - Change flag set when direction differs from previous
// RULE6 - High flag set beyond outer threshold, positive
// RULE7 - Low flag set beyond outer threshold, negative
// RULE8 - Flags clear below inner threshold: hysteresis
// RULE9 - Acknowledge read refreshes source, returns zero
// RULE10 - Inner threshold built from two byte registers
// RULE11 - Outer threshold built from two byte registers
// RULE12 - Filter select chooses filtered or raw samples
// RULE13 - Unlatched: flags follow each sample; irq from enables
//----------------------------------------------------------------------
package direction_pkg;
    localparam logic [7:0] ADDR_CONFIG     = 8'h38;
    localparam logic [7:0] ADDR_SOURCE     = 8'h39;
    localparam logic [7:0] ADDR_ACK        = 8'h3A;
    localparam logic [7:0] ADDR_INNER_LOW  = 8'h3C;
    localparam logic [7:0] ADDR_INNER_HIGH = 8'h3D;
    localparam logic [7:0] ADDR_OUTER_LOW  = 8'h3E;
    localparam logic [7:0] ADDR_OUTER_HIGH = 8'h3F;
    // Config field positions
    localparam int CFG_IRQ_EN_BIT  = 7;
    localparam int CFG_LATCH_BIT   = 6;
    // Source field positions
    localparam int SRC_CHANGE_BIT  = 6;
    // Reset values
    localparam logic [7:0]  CONFIG_RESET    = 8'h00;
    localparam logic [7:0]  SOURCE_RESET    = 8'h00;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0]  READ_ZERO       = 8'h00;
    typedef logic [15:0] sample_t;
endpackage

/* File: rtl/axis_bus_if.sv */
// Interface carrying per-axis samples and flags between detector modules
`timescale 1ns/1ps
interface axis_bus_if;
    logic signed [15:0] sample;
    logic [15:0]        inner_thr;
    logic [15:0]        outer_thr;
    logic               high_prev;
    logic               low_prev;
    logic               high_next;
    logic               low_next;
    modport cmp (input sample, inner_thr, outer_thr, high_prev, low_prev,
                 output high_next, low_next);
    modport top (output sample, inner_thr, outer_thr, high_prev, low_prev,
                 input high_next, low_next);
endinterface

/* File: rtl/axis_hysteresis.sv */
// Per-axis hysteresis comparator
`timescale 1ns/1ps
module axis_hysteresis (
    axis_bus_if.cmp ab
);
    logic signed [16:0] s_ext;
    logic signed [16:0] neg_s;
    logic signed [16:0] in_ext;
    logic signed [16:0] out_ext;
    logic               above_pos;
    logic               above_neg;
    logic               inside_pos;
    logic               inside_neg;

    assign s_ext      = {ab.sample[15], ab.sample};
    assign neg_s      = -s_ext;
    assign in_ext     = {1'b0, ab.inner_thr};
    assign out_ext    = {1'b0, ab.outer_thr};
    assign above_pos  = s_ext > out_ext;                       // [RULE6]
    assign above_neg  = neg_s > out_ext;                       // [RULE7]
    assign inside_pos = s_ext < in_ext;                        // [RULE8]
    assign inside_neg = neg_s < in_ext;                        // [RULE8]
    // Between thresholds the previous flag is kept
    assign ab.high_next = above_pos | (ab.high_prev & ~inside_pos);
    assign ab.low_next  = above_neg | (ab.low_prev & ~inside_neg);
endmodule

/* File: test/host_model.sv */
// Host processor model driving the detector's register port
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic       sys_clk_i,
    // Register port
    input  wire logic [7:0] reg_rdata_i,
    output logic [7:0]      reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_wdata_o
);
    //------------------------------------------------------------------
    // Bus cycles
    //------------------------------------------------------------------
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask
    // Acknowledge reads also go through here
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask
endmodule

/* File: test/direction_change_detector_tb_top.sv */
// Self-checking bench for the direction-change detector
`timescale 1ns/1ps
module direction_change_detector_tb_top;
    import direction_pkg::*;
    logic        sys_clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        valid;
    sample_t     raw [3];
    sample_t     filt [3];
    logic        fsel;
    logic [7:0]  r_addr;
    logic        r_wr;
    logic        r_rd;
    logic [7:0]  r_wdata;
    logic [7:0]  r_rdata;
    logic        irq;
    int          err_count;
    int          num_checks;
    int          seed;
    logic [7:0]  cfg;
    logic [7:0]  src;
    logic [5:0]  prev;
    logic [15:0] inner;
    logic [15:0] outer;
    logic [7:0]  rd;
    sample_t     v;
    logic [7:0]  addrs [8] = '{ADDR_CONFIG, ADDR_SOURCE, ADDR_ACK,
        ADDR_INNER_LOW, ADDR_INNER_HIGH, ADDR_OUTER_LOW, ADDR_OUTER_HIGH,
        8'h3B};

    direction_change_detector direction_change_detector_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .sample_valid_i(valid), .raw_x_i(raw[0]), .raw_y_i(raw[1]),
        .raw_z_i(raw[2]), .filt_x_i(filt[0]), .filt_y_i(filt[1]),
        .filt_z_i(filt[2]), .direction_filter_select_i(fsel),
        .reg_addr_i(r_addr), .reg_wr_i(r_wr), .reg_rd_i(r_rd),
        .reg_wdata_i(r_wdata), .reg_rdata_o(r_rdata),
        .direction_irq_o(irq));
    host_model host_model_inst (
        .sys_clk_i(sys_clk_i), .reg_rdata_i(r_rdata), .reg_addr_o(r_addr),
        .reg_wr_o(r_wr), .reg_rd_o(r_rd), .reg_wdata_o(r_wdata));

    //------------------------------------------------------------------
    // Expectations and comparisons
    //------------------------------------------------------------------
    function automatic logic [1:0] axis(sample_t x, logic [1:0] p);
        logic signed [17:0] s;
        logic signed [17:0] hi;
        logic signed [17:0] lo;
        s  = $signed({{2{x[15]}}, x});
        hi = $signed({2'b00, outer});
        lo = $signed({2'b00, inner});
        axis[1] = (s > hi) ? 1'b1 : ((s < lo) ? 1'b0 : p[1]);
        axis[0] = (-s > hi) ? 1'b1 : ((-s < lo) ? 1'b0 : p[0]);
    endfunction
    function automatic logic exp_irq(logic [7:0] c, logic [7:0] s);
        return c[7] & s[6] & (|(s[5:0] & c[5:0]));
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t byte got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t irq got %b exp %b", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_model_inst.read(a, rd);
        chk8(rd, e);
    endtask
    // Unselected source carries the inverse so a wrong pick shows
    task automatic sample(input sample_t x, y, z, input logic fs);
        logic [5:0] f;
        sample_t    s [3];
        s = '{x, y, z};
        @(posedge sys_clk_i);
        valid <= 1'b1;
        fsel  <= fs;
        for (int i = 0; i < 3; i++) begin
            raw[i]  <= fs ? ~s[i] : s[i];
            filt[i] <= fs ? s[i] : ~s[i];
            f[2*i +: 2] = axis(s[i], prev[2*i +: 2]);
        end
        @(posedge sys_clk_i);
        valid <= 1'b0;
        if (cfg[6] && src[6]) src = src | {1'b0, f != prev, f};
        else src = {1'b0, f != prev, f};
        prev = f;
        #1 chk1(irq, exp_irq(cfg, src));
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    //------------------------------------------------------------------
    // Clock, watchdog and sequence
    //------------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #(100 * 20000);
        err_count++;
        complete_run();
    end
    initial begin
        seed = 6914;
        {rst_i, ce_i, valid, fsel} = 4'b1100;
        raw  = '{16'h0000, 16'h0000, 16'h0000};
        filt = '{16'h0000, 16'h0000, 16'h0000};
        {cfg, src, prev, inner, outer} = '0;
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rchk(addrs[i], 8'h00);
        inner = 16'h2000 + 16'($random(seed) & 32'h0FFF);
        outer = inner + 16'h3000;
        host_model_inst.write(ADDR_INNER_LOW, inner[7:0]);
        host_model_inst.write(ADDR_INNER_HIGH, inner[15:8]);
        host_model_inst.write(ADDR_OUTER_LOW, outer[7:0]);
        host_model_inst.write(ADDR_OUTER_HIGH, outer[15:8]);
        host_model_inst.write(ADDR_SOURCE, 8'hFF);
        rchk(ADDR_INNER_LOW, inner[7:0]);
        rchk(ADDR_INNER_HIGH, inner[15:8]);
        rchk(ADDR_OUTER_LOW, outer[7:0]);
        rchk(ADDR_OUTER_HIGH, outer[15:8]);
        rchk(ADDR_SOURCE, 8'h00);
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        host_model_inst.write(ADDR_CONFIG, 8'hFF);
        ce_i <= 1'b1;
        rchk(ADDR_CONFIG, 8'h00);
        cfg = 8'hBF;
        host_model_inst.write(ADDR_CONFIG, cfg);
        rchk(ADDR_CONFIG, cfg);
        // Threshold edges: at outer, just above, at inner, just below
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? outer : (k == 1) ? outer + 16'h0001 :
                (k == 2) ? inner : inner - 16'h0001;
            sample(v, -v, 16'h0000, k[0]);
            rchk(ADDR_SOURCE, src);
        end
        // High-only, then low-only enables against a low event
        for (int k = 0; k < 2; k++) begin
            cfg = k[0] ? 8'h95 : 8'h8A;
            host_model_inst.write(ADDR_CONFIG, cfg);
            sample(-(outer + 16'h0001), 16'h0000, 16'h0000, k[0]);
            rchk(ADDR_SOURCE, src);
            sample(16'h0000, 16'h0000, 16'h0000, 1'b0);
        end
        for (int n = 0; n < 40; n++) begin
            if (n % 10 == 0) begin
                cfg = 8'($random(seed)) & 8'hBF;
                host_model_inst.write(ADDR_CONFIG, cfg);
            end
            sample(16'($random(seed)), 16'($random(seed)),
                   16'($random(seed)), 1'($random(seed)));
            rchk(ADDR_SOURCE, src);
        end
        cfg = 8'hFF;
        host_model_inst.write(ADDR_CONFIG, cfg);
        sample(16'h0000, 16'h0000, 16'h0000, 1'b0);
        rchk(ADDR_ACK, READ_ZERO);
        src = 8'h00;
        sample(outer + 16'h0001, 16'h0000, 16'h0000, 1'b1);
        sample(outer + 16'h0001, 16'h0000, 16'h0000, 1'b0);
        rchk(ADDR_SOURCE, src);
        rchk(ADDR_ACK, READ_ZERO);
        rchk(ADDR_SOURCE, 8'h00);
        complete_run();
    end
endmodule
